/* File: hw/pump_seq_regs.vh */
// Constants of the pump program phase sequencer
`ifndef PUMP_SEQ_REGS_VH
`define PUMP_SEQ_REGS_VH
// ************************************************************
// Register port map
// ************************************************************
`define A_W          6
`define D_W          48
`define A_CTRL       6'h30
`define A_STAT       6'h31
`define A_TOT_INF    6'h32
`define A_TOT_WDR    6'h33
`define CTRL_ALARM   0
`define CTRL_LOCK    1
// ************************************************************
// Phase word layout
// ************************************************************
`define F_OP_HI      47
`define F_OP_LO      44
`define F_DIR        43
`define F_TENTH      42
`define F_PAR_HI     39
`define F_PAR_LO     32
`define F_RATE_HI    31
`define F_RATE_LO    16
`define F_VOL_HI     15
`define F_VOL_LO     0
// ************************************************************
// Phase functions
// ************************************************************
`define OP_STOP      4'h0
`define OP_RATE      4'h1
`define OP_FILL      4'h2
`define OP_STEP_UP   4'h3
`define OP_STEP_DN   4'h4
`define OP_GOTO      4'h5
`define OP_SELECT    4'h6
`define OP_LABEL     4'h7
`define OP_LBEGIN    4'h8
`define OP_LFOREVER  4'h9
`define OP_LCOUNT    4'ha
`define OP_HOLD      4'hb
// ************************************************************
// Limits and timing
// ************************************************************
`define PH_FIRST     6'h01
`define PH_LAST      6'h29
`define LABEL_MAX    8'h63
`define LOOP_DEPTH   2'h3
`define TENTHS_SEC   4'h9
`define TENTH_NS     100000000
`define CLK_NS       5
`endif

/* File: hw/pump_phase_sequencer.v */
// Program phase sequencer for a syringe pump
`timescale 1ns/100ps
`include "pump_seq_regs.vh"
module pump_phase_sequencer #(
    parameter TENTH_CYCLES = `TENTH_NS / `CLK_NS
) (
    input  wire                clk,
    input  wire                rst,
    input  wire [`A_W-1:0]     addr,
    input  wire [`D_W-1:0]     wr_data,
    input  wire                wr_en,
    input  wire                rd_en,
    output reg  [`D_W-1:0]     rd_data,
    input  wire                key_start,
    input  wire                key_other,
    input  wire                trig_start,
    input  wire                serial_start,
    input  wire                label_set,
    input  wire [7:0]          label_val,
    input  wire                vol_tick,
    output reg                 motor_run,
    output reg                 motor_dir,
    output reg  [15:0]         motor_rate,
    output reg  [15:0]         infused_total,
    output reg  [15:0]         withdrawn_total,
    output reg                 buzzer,
    output reg  [7:0]          disp_value,
    output reg  [5:0]          phase_now,
    output reg                 prog_error,
    output reg                 range_error
);
    // ************************************************************
    // States
    // ************************************************************
    localparam S_IDLE   = 8'h01;
    localparam S_FETCH  = 8'h02;
    localparam S_PUMP   = 8'h04;
    localparam S_HOLD   = 8'h08;
    localparam S_WAIT   = 8'h10;
    localparam S_SELECT = 8'h20;
    localparam S_SEARCH = 8'h40;
    localparam S_PAUSED = 8'h80;

    // Next phase number, zero when past the last phase
    function [5:0] nxt;
        input [5:0] p;
        begin
            nxt = (p == `PH_LAST) ? 6'h00 : p + 6'h01;
        end
    endfunction

    // Opcode field of a phase word
    function [3:0] op_of;
        input [`D_W-1:0] w;
        begin
            op_of = w[`F_OP_HI:`F_OP_LO];
        end
    endfunction

    reg [`D_W-1:0] prog_q [0:`PH_LAST-1];
    reg [7:0]      state_q;
    reg [5:0]      pc_q;
    reg [1:0]      ctrl_q;
    reg            boot_q;
    reg            stopped_q;
    reg            base_ok_q;
    reg [15:0]     rate_q;
    reg            dir_q;
    reg            cont_q;
    reg [15:0]     lim_q;
    reg [15:0]     ph_vol_q;
    reg [15:0]     disp_vol_q;
    reg [5:0]      lp_start_q [0:2];
    reg [7:0]      lp_cnt_q [0:2];
    reg [1:0]      depth_q;
    reg [7:0]      sec_q;
    reg [3:0]      sub_q;
    reg            tenth_mode_q;
    reg [24:0]     cyc_q;
    reg [7:0]      label_q;
    reg [5:0]      srch_q;
    reg [5:0]      srch_n_q;
    reg [2:0]      ks_q, ko_q, tr_q, vt_q;
    integer        i;

    wire [`D_W-1:0] cur     = prog_q[pc_q - 6'h01];
    wire [3:0]      cur_op  = op_of(cur);
    wire [7:0]      cur_par = cur[`F_PAR_HI:`F_PAR_LO];
    wire [15:0]     cur_rt  = cur[`F_RATE_HI:`F_RATE_LO];
    wire [`D_W-1:0] sw      = prog_q[srch_q - 6'h01];
    wire            ks_rise = ks_q[1] & ~ks_q[2];
    wire            ko_rise = ko_q[1] & ~ko_q[2];
    wire            tr_rise = tr_q[1] & ~tr_q[2];
    wire            tick    = vt_q[1] & ~vt_q[2];
    wire            start   = ks_rise | tr_rise | serial_start;
    wire            tenth   = (cyc_q == TENTH_CYCLES[24:0] - 25'h1);
    wire [1:0]      top     = depth_q - 2'h1;

    // ************************************************************
    // Pin synchronisers and edge detect
    // ************************************************************
    always @(posedge clk) begin
        if (rst) begin
            ks_q <= 3'h0;
            ko_q <= 3'h0;
            tr_q <= 3'h0;
            vt_q <= 3'h0;
        end else begin
            ks_q <= {ks_q[1:0], key_start};
            ko_q <= {ko_q[1:0], key_other};
            tr_q <= {tr_q[1:0], trig_start};
            vt_q <= {vt_q[1:0], vol_tick};
        end
    end

    // ************************************************************
    // Register port: program store, control, status
    // ************************************************************
    always @(posedge clk) begin
        if (rst) begin
            rd_data <= {`D_W{1'b0}};
            ctrl_q  <= 2'h0;
        end else begin
            if (wr_en && addr == `A_CTRL)
                ctrl_q <= wr_data[1:0];
            if (!rd_en)
                rd_data <= {`D_W{1'b0}};
            else if (addr >= `PH_FIRST && addr <= `PH_LAST)
                rd_data <= prog_q[addr - 6'h01];
            else if (addr == `A_CTRL)
                rd_data <= {46'h0, ctrl_q};
            else if (addr == `A_STAT)
                rd_data <= {30'h0, range_error, prog_error, depth_q, pc_q, state_q};
            else if (addr == `A_TOT_INF)
                rd_data <= {32'h0, infused_total};
            else if (addr == `A_TOT_WDR)
                rd_data <= {32'h0, withdrawn_total};
            else
                rd_data <= {`D_W{1'b0}};
        end
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    always @(posedge clk) begin
        if (rst) begin
            state_q <= S_IDLE;
            pc_q <= `PH_FIRST;
            boot_q <= 1'b1;
            stopped_q <= 1'b0;
            base_ok_q <= 1'b0;
            rate_q <= 16'h0;
            dir_q <= 1'b0;
            cont_q <= 1'b0;
            lim_q <= 16'h0;
            ph_vol_q <= 16'h0;
            disp_vol_q <= 16'h0;
            depth_q <= 2'h0;
            sec_q <= 8'h0;
            sub_q <= 4'h0;
            tenth_mode_q <= 1'b0;
            cyc_q <= 25'h0;
            label_q <= 8'h0;
            srch_q <= 6'h0;
            srch_n_q <= 6'h0;
            prog_error <= 1'b0;
            range_error <= 1'b0;
            infused_total <= 16'h0;
            withdrawn_total <= 16'h0;
            for (i = 0; i < 3; i = i + 1) begin
                lp_start_q[i] <= 6'h0;
                lp_cnt_q[i] <= 8'h0;
            end
            for (i = 0; i < `PH_LAST; i = i + 1)
                prog_q[i] <= {`D_W{1'b0}};
        end else begin
            cyc_q <= tenth ? 25'h0 : cyc_q + 25'h1;
            if (wr_en && addr >= `PH_FIRST && addr <= `PH_LAST)
                prog_q[addr - 6'h01] <= wr_data;
            // Volume accounting while the motor turns
            if (state_q == S_PUMP && tick) begin
                ph_vol_q <= ph_vol_q + 16'h1;
                if (!cont_q)
                    disp_vol_q <= disp_vol_q + 16'h1;
                if (dir_q)
                    withdrawn_total <= withdrawn_total + 16'h1;
                else
                    infused_total <= infused_total + 16'h1;
            end
            case (state_q)
                S_IDLE: begin
                    // Power-on auto run when lockout is set and phase 1 is a select phase
                    if (start || (boot_q && ctrl_q[`CTRL_LOCK] && op_of(prog_q[0]) == `OP_SELECT)) begin
                        state_q <= S_FETCH;
                        pc_q <= `PH_FIRST;
                        boot_q <= 1'b0;
                        stopped_q <= 1'b0;
                        base_ok_q <= 1'b0;
                        prog_error <= 1'b0;
                        depth_q <= 2'h0;
                    end
                end
                S_FETCH: begin
                    // One phase decoded per visit
                    ph_vol_q <= 16'h0;
                    case (cur_op)
                        `OP_RATE, `OP_FILL, `OP_STEP_UP, `OP_STEP_DN: begin
                            if ((cur_op == `OP_STEP_UP || cur_op == `OP_STEP_DN) && !base_ok_q) begin
                                prog_error <= 1'b1;
                                stopped_q <= 1'b1;
                                state_q <= S_IDLE;
                            end else begin
                                state_q <= S_PUMP;
                                base_ok_q <= 1'b1;
                                if (cur_op == `OP_FILL) begin
                                    dir_q <= ~dir_q;
                                    lim_q <= disp_vol_q;
                                    disp_vol_q <= 16'h0;
                                    cont_q <= 1'b1;
                                    if (cur_rt != 16'h0)
                                        rate_q <= cur_rt;
                                end else begin
                                    dir_q <= cur[`F_DIR];
                                    lim_q <= cur[`F_VOL_HI:`F_VOL_LO];
                                    cont_q <= 1'b0;
                                    if (cur_op == `OP_RATE)
                                        rate_q <= cur_rt;
                                    else if (cur_op == `OP_STEP_UP)
                                        rate_q <= rate_q + cur_rt;
                                    else
                                        rate_q <= rate_q - cur_rt;
                                end
                            end
                        end
                        `OP_GOTO: begin
                            if (cur_par[5:0] >= `PH_FIRST && cur_par[5:0] <= `PH_LAST)
                                pc_q <= cur_par[5:0];
                            else begin
                                stopped_q <= 1'b1;
                                state_q <= S_IDLE;
                            end
                        end
                        `OP_LABEL: pc_q <= `PH_FIRST;
                        `OP_SELECT: begin
                            state_q <= S_SELECT;
                            label_q <= cur_par;
                        end
                        `OP_LBEGIN: begin
                            if (depth_q != `LOOP_DEPTH) begin
                                lp_start_q[depth_q] <= nxt(pc_q);
                                lp_cnt_q[depth_q] <= 8'h0;
                                depth_q <= depth_q + 2'h1;
                            end
                            pc_q <= nxt(pc_q);
                            if (nxt(pc_q) == 6'h00) begin
                                stopped_q <= 1'b1;
                                state_q <= S_IDLE;
                            end
                        end
                        `OP_LFOREVER, `OP_LCOUNT: begin
                            if (depth_q == 2'h0) begin
                                // Implied begin at phase 1
                                lp_start_q[0] <= `PH_FIRST;
                                lp_cnt_q[0] <= 8'h1;
                                depth_q <= 2'h1;
                                pc_q <= `PH_FIRST;
                                if (cur_op == `OP_LCOUNT && cur_par <= 8'h1) begin
                                    depth_q <= 2'h0;
                                    pc_q <= nxt(pc_q);
                                end
                            end else if (cur_op == `OP_LCOUNT && lp_cnt_q[top] + 8'h1 >= cur_par) begin
                                depth_q <= top;
                                pc_q <= nxt(pc_q);
                            end else begin
                                lp_cnt_q[top] <= lp_cnt_q[top] + 8'h1;
                                pc_q <= lp_start_q[top];
                            end
                            if (cur_op == `OP_LCOUNT && nxt(pc_q) == 6'h00 &&
                                ((depth_q == 2'h0 && cur_par <= 8'h1) ||
                                 (depth_q != 2'h0 && lp_cnt_q[top] + 8'h1 >= cur_par))) begin
                                stopped_q <= 1'b1;
                                state_q <= S_IDLE;
                            end
                        end
                        `OP_HOLD: begin
                            base_ok_q <= 1'b0;
                            sec_q <= cur_par;
                            tenth_mode_q <= cur[`F_TENTH];
                            sub_q <= `TENTHS_SEC;
                            state_q <= (cur_par == 8'h0) ? S_WAIT : S_HOLD;
                        end
                        default: begin
                            stopped_q <= 1'b1;
                            state_q <= S_IDLE;
                            pc_q <= `PH_FIRST;
                        end
                    endcase
                end
                S_PUMP: begin
                    // Phase ends on its volume limit
                    if (tick && lim_q != 16'h0 && ph_vol_q + 16'h1 >= lim_q) begin
                        pc_q <= nxt(pc_q);
                        state_q <= (nxt(pc_q) == 6'h00) ? S_IDLE : S_FETCH;
                        stopped_q <= (nxt(pc_q) == 6'h00);
                    end else if (ks_rise && lim_q == 16'h0 && cur_op == `OP_RATE)
                        state_q <= S_PAUSED;
                end
                S_PAUSED: begin
                    if (tr_rise) begin
                        pc_q <= `PH_FIRST;
                        depth_q <= 2'h0;
                        base_ok_q <= 1'b0;
                        state_q <= S_FETCH;
                    end else if (ks_rise)
                        state_q <= S_PUMP;
                end
                S_HOLD: begin
                    if (tenth) begin
                        if (tenth_mode_q || sub_q == 4'h0) begin
                            sub_q <= `TENTHS_SEC;
                            sec_q <= sec_q - 8'h1;
                            if (sec_q == 8'h1) begin
                                pc_q <= nxt(pc_q);
                                state_q <= (nxt(pc_q) == 6'h00) ? S_IDLE : S_FETCH;
                                stopped_q <= (nxt(pc_q) == 6'h00);
                            end
                        end else
                            sub_q <= sub_q - 4'h1;
                    end
                end
                S_WAIT: begin
                    if (start) begin
                        pc_q <= nxt(pc_q);
                        state_q <= (nxt(pc_q) == 6'h00) ? S_IDLE : S_FETCH;
                        stopped_q <= (nxt(pc_q) == 6'h00);
                    end else if (ko_rise) begin
                        pc_q <= `PH_FIRST;
                        depth_q <= 2'h0;
                        stopped_q <= 1'b1;
                        state_q <= S_IDLE;
                    end
                end
                S_SELECT: begin
                    if (range_error) begin
                        if (ks_rise || ko_rise)
                            range_error <= 1'b0;
                    end else if (label_set)
                        label_q <= (label_val > `LABEL_MAX) ? `LABEL_MAX : label_val;
                    else if (start) begin
                        srch_q <= pc_q;
                        srch_n_q <= 6'h0;
                        state_q <= S_SEARCH;
                    end
                end
                S_SEARCH: begin
                    if (op_of(sw) == `OP_LABEL && sw[`F_PAR_HI:`F_PAR_LO] == label_q) begin
                        prog_q[pc_q - 6'h01][`F_PAR_HI:`F_PAR_LO] <= label_q;
                        infused_total <= 16'h0;
                        withdrawn_total <= 16'h0;
                        depth_q <= 2'h0;
                        pc_q <= nxt(srch_q);
                        state_q <= (nxt(srch_q) == 6'h00) ? S_IDLE : S_FETCH;
                        stopped_q <= (nxt(srch_q) == 6'h00);
                    end else if (srch_n_q == `PH_LAST - 6'h01) begin
                        range_error <= 1'b1;
                        state_q <= S_SELECT;
                    end else begin
                        srch_n_q <= srch_n_q + 6'h1;
                        srch_q <= (srch_q == `PH_LAST) ? `PH_FIRST : srch_q + 6'h1;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Motor, display and buzzer outputs
    // ************************************************************
    always @(posedge clk) begin
        if (rst) begin
            motor_run <= 1'b0;
            motor_dir <= 1'b0;
            motor_rate <= 16'h0;
            buzzer <= 1'b0;
            disp_value <= 8'h0;
            phase_now <= `PH_FIRST;
        end else begin
            motor_run <= (state_q == S_PUMP);
            motor_dir <= dir_q;
            motor_rate <= rate_q;
            // A run that fell off the last phase shows phase 1, where the next start begins
            phase_now <= (pc_q == 6'h00) ? `PH_FIRST : pc_q;
            buzzer <= ctrl_q[`CTRL_ALARM] & (stopped_q | (state_q == S_WAIT) | (state_q == S_SELECT));
            if (state_q == S_HOLD)
                disp_value <= tenth_mode_q ? 8'h01 : sec_q;
            else if (state_q == S_SELECT)
                disp_value <= label_q;
            else
                disp_value <= {2'h0, pc_q};
        end
    end
endmodule // pump_phase_sequencer

/* File: tb/pump_seq_monitor.sv */
// Port checker of the phase sequencer
`timescale 1ns/100ps
`include "pump_seq_regs.vh"
module pump_seq_monitor (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [5:0]  addr,
    input wire logic        rd_en,
    input wire logic [47:0] rd_data,
    input wire logic        motor_run,
    input wire logic [15:0] infused_total,
    input wire logic        buzzer,
    input wire logic [5:0]  phase_now,
    input wire logic        prog_error,
    input wire logic        range_error
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Read of a place past the last phase
    sequence beyond_rd; rd_en && addr > `PH_LAST && addr < `A_CTRL; endsequence
    AST_BEYOND_ZERO: assert property (beyond_rd |=> rd_data == 0)
        else $error("read past store not zero");
    AST_PH_RANGE: assert property (phase_now >= 1 && phase_now <= `PH_LAST)
        else $error("phase out of range");
    AST_RESET_PH1: assert property ($fell(rst) |-> phase_now == 6'h01)
        else $error("phase not one after reset");
    AST_ERR_HALT: assert property ($rose(prog_error) |-> !motor_run [*3])
        else $error("motor runs after error");
    AST_BUZZ_QUIET: assert property (buzzer |-> !motor_run)
        else $error("buzzer while pumping");
    AST_RANGE_QUIET: assert property (range_error |-> !motor_run)
        else $error("pumping with range error");
    AST_INF_STEP: assert property ($changed(infused_total) |->
        infused_total == $past(infused_total) + 16'h1 || infused_total == 0) else $error("total jump");
    AST_TOT_READ: assert property (rd_en && addr == `A_TOT_INF |=>
        rd_data == {32'h0, $past(infused_total)}) else $error("total read wrong");
endmodule // pump_seq_monitor
bind pump_phase_sequencer pump_seq_monitor u_mon (.clk(clk), .rst(rst), .addr(addr),
    .rd_en(rd_en), .rd_data(rd_data), .motor_run(motor_run), .infused_total(infused_total),
    .buzzer(buzzer), .phase_now(phase_now), .prog_error(prog_error), .range_error(range_error));

/* File: tb/pump_drive_model.sv */
// Motor drive model that reports moved volume units
`timescale 1ns/100ps
module pump_drive_model #(
    parameter int GAP = 6
) (
    input  wire logic clk,
    input  wire logic motor_run,
    output logic      vol_tick
);
    int cnt = 0;
    initial vol_tick = 1'b0;
    // Toggle the unit pin every GAP cycles while turning
    always @(posedge clk) begin
        cnt <= motor_run ? (cnt + 1) % GAP : 0;
        if (motor_run && cnt == GAP - 1) vol_tick <= !vol_tick;
    end
endmodule // pump_drive_model

/* File: tb/pump_program_phase_sequencer_bench.sv */
// Self-checking bench of the phase sequencer
`timescale 1ns/100ps
`include "pump_seq_regs.vh"
module pump_program_phase_sequencer_bench;
    logic clk = 0, rst = 1, wr_en = 0, rd_en = 0, go_q = 0, vol_tick;
    logic [5:0] addr = 0, phase_now;
    logic [47:0] wr_data = 0, rd_data;
    logic [15:0] motor_rate, infused_total, withdrawn_total;
    logic other_key = 0, lbl_set = 0;
    logic [7:0] lbl_val = 0, disp_value;
    logic motor_run, motor_dir, buzzer, prog_error, range_error;
    int n_fail = 0, tests_run = 0;
    wire [4:0] flags = {range_error, motor_dir, prog_error, buzzer, motor_run};
    initial forever #2.5 clk = !clk;
    pump_phase_sequencer #(.TENTH_CYCLES(10)) DUT (.clk(clk), .rst(rst), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .key_start(1'b0),
        .key_other(other_key), .trig_start(1'b0), .serial_start(go_q), .label_set(lbl_set),
        .label_val(lbl_val), .vol_tick(vol_tick), .motor_run(motor_run), .motor_dir(motor_dir),
        .motor_rate(motor_rate), .infused_total(infused_total), .withdrawn_total(withdrawn_total),
        .buzzer(buzzer), .disp_value(disp_value), .phase_now(phase_now), .prog_error(prog_error),
        .range_error(range_error));
    pump_drive_model #(.GAP(6)) u_drive (.clk(clk), .motor_run(motor_run), .vol_tick(vol_tick));
    task automatic chk(input string nm, input logic [47:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Register port cycles and start pulse
    task automatic wr(input logic [5:0] a, input logic [47:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1;
        @(posedge clk);
        wr_en <= 0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [47:0] exp);
        @(posedge clk);
        addr <= a;
        rd_en <= 1;
        @(posedge clk);
        rd_en <= 0;
        #1 chk("rd_data", rd_data, exp);
    endtask
    task automatic go;
        @(posedge clk);
        go_q <= 1;
        @(posedge clk);
        go_q <= 0;
    endtask
    // One-cycle label load at the select prompt
    task automatic lbl(input logic [7:0] v);
        @(posedge clk);
        lbl_set <= 1;
        lbl_val <= v;
        @(posedge clk);
        lbl_set <= 0;
    endtask
    task automatic wt(input int s);
        int i;
        for (i = 0; i < 4000 && flags[s] !== 1'b1; i++) @(posedge clk);
        #1 chk("wait", i < 4000, 1);
    endtask
    function automatic logic [47:0] ph(input logic [3:0] op, input logic [7:0] p, input logic [15:0] r, v);
        return {op, 4'h0, p, r, v};
    endfunction
    // Reset, alarm on, load up to three phases
    task automatic setup(input logic [47:0] a, b, c);
        if (!rst) @(posedge clk);
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        wr(`A_CTRL, 1);
        wr(1, a);
        wr(2, b);
        wr(3, c);
    endtask
    // Rate, goto and stop; read past the store
    task automatic t_rate;
        setup(ph(`OP_RATE, 0, 16'h10, 2), ph(`OP_GOTO, 4, 0, 0), ph(`OP_RATE, 0, 16'h77, 5));
        go;
        wt(0);
        chk("motor_rate", motor_rate, 16'h10);
        wt(1);
        chk("infused_total", infused_total, 2);
        rd(6'h2a, 0);
    endtask
    // Fill with zero rate withdraws the dispensed volume at the previous rate
    task automatic t_fill;
        setup(ph(`OP_RATE, 0, 16'h10, 2), ph(`OP_FILL, 0, 0, 0), 0);
        go;
        wt(3);
        chk("fill_rate", motor_rate, 16'h10);
        wt(1);
        chk("withdrawn_total", withdrawn_total, 2);
        chk("infused_total", infused_total, 2);
    endtask
    // Step phase with no base rate
    task automatic t_step;
        setup(ph(`OP_STEP_UP, 0, 4, 0), 0, 0);
        go;
        wt(2);
        chk("motor_run", motor_run, 0);
    endtask
    // Counted loop of three passes
    task automatic t_loop;
        setup(ph(`OP_RATE, 0, 16'h20, 1), ph(`OP_LBEGIN, 0, 0, 0), ph(`OP_RATE, 0, 16'h20, 1));
        wr(4, ph(`OP_LCOUNT, 3, 0, 0));
        go;
        wt(1);
        rd(`A_TOT_INF, 4);
    endtask
    // Select prompt: a missing label, a key, then a label that exists
    task automatic t_label;
        setup(ph(`OP_SELECT, 0, 0, 0), ph(`OP_RATE, 0, 16'h20, 0), ph(`OP_LABEL, 5, 0, 0));
        wr(4, ph(`OP_RATE, 0, 16'h40, 1));
        go;
        lbl(7);
        go;
        wt(4);
        @(posedge clk);
        other_key <= 1;
        repeat (4) @(posedge clk);
        other_key <= 0;
        lbl(5);
        repeat (2) @(posedge clk);
        #1 chk("disp_value", disp_value, 5);
        chk("range_error", range_error, 0);
        go;
        wt(0);
        chk("motor_rate", motor_rate, 16'h40);
        rd(1, ph(`OP_SELECT, 5, 0, 0));
    endtask
    // Hold of zero waits for a start
    task automatic t_hold;
        setup(ph(`OP_HOLD, 0, 0, 0), ph(`OP_RATE, 0, 16'h30, 1), 0);
        go;
        wt(1);
        chk("motor_run", motor_run, 0);
        go;
        wt(0);
        chk("motor_rate", motor_rate, 16'h30);
    endtask
    initial begin
        t_rate;
        t_fill;
        t_step;
        t_loop;
        t_label;
        t_hold;
        print_verdict;
    end
    // Watchdog against a hang
    initial begin
        #200000;
        n_fail++;
        print_verdict;
    end
endmodule // pump_program_phase_sequencer_bench
